// >>> hw/ldc_lane_align.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"

module ldc_lane_align #(
   parameter int LANES = `LDC_LANES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic soft_rst,
   // Lane alignment events
   input wire ldc_pkg::ldc_lane_evt_type lane_evt,
   // Status
   output logic [LANES-1:0] flag_r,
   output logic gained,
   output logic lost
);
   import ldc_pkg::*;

   logic [LANES-1:0] flag_nxt;

   // ----------------------------------------------------------------
   // Per-lane flags
   // ----------------------------------------------------------------
   // Loss beats completion in the same cycle, since a lane that just
   // slipped cannot be trusted as aligned.
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1)
      begin : gen_lane
         always_comb
         begin
            if (soft_rst)
               flag_nxt[g] = 1'b0;
            else if (lane_evt.lost[g])
               flag_nxt[g] = 1'b0; // [R9]
            else if (lane_evt.done[g])
               flag_nxt[g] = 1'b1; // [R9]
            else
               flag_nxt[g] = flag_r[g];
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_r <= LANES'(`LDC_DESKEW_RESET);
      else
         flag_r <= flag_nxt; // [R7]
   end

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   assign gained = (&flag_nxt) && !(&flag_r);
   assign lost = |(flag_r & ~flag_nxt);

endmodule

`default_nettype wire

// >>> hw/ldc_top.sv
// Notes on behaviour
// [R1] Density bit (bit 7) always reads 1; writes ignored.
// [R2] Bits 4:0 give control bits per sample, read-only, reset zero.
// [R3] Control-bits-per-sample applies to link 0 only; other links read zero.
// [R4] Paged registers follow the link page selector at index 0x300.
// [R5] Two reserved parameter bytes per link, read/write, reset zero.
// [R6] Software writes checksum only while deskew unit is in soft reset.
// [R7] Deskew status bit n shows lane n: 1 achieved, 0 failed; read-only.
// [R8] Lane 0 deskew status sits in bit 0 with the same encoding.
// [R9] Deskew bits follow the alignment logic; software writes never touch them. A write that sets the soft reset bit clears them.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"

module ldc_top #(
   parameter int NUM_LINKS = `LDC_LINKS,
   parameter int LANES = `LDC_LANES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link layer
   input wire logic [4:0] ctrl_bits_per_sample_field,
   input wire ldc_pkg::ldc_lane_evt_type lane_evt [NUM_LINKS],
   // Configuration towards the link layer
   output ldc_pkg::ldc_link_cfg_type link_cfg [NUM_LINKS],
   output logic deskew_soft_rst,
   // Interrupt
   output logic irq
);
   import ldc_pkg::*;

   localparam int LINK_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
   localparam int IRQ_W = 2 * NUM_LINKS + 1;
   localparam int CKSUM_EVT = 2 * NUM_LINKS;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic idx_hit(input logic [15:0] addr, input logic [11:0] idx);
      idx_hit = (addr == {2'b00, idx, 2'b00});
   endfunction

   function automatic ldc_sel_type decode(input logic [15:0] addr);
      if (idx_hit(addr, `LDC_IDX_LINK_PAGE))
         decode = LDC_SEL_PAGE;
      else if (idx_hit(addr, `LDC_IDX_DENS_CTRL))
         decode = LDC_SEL_DENS_CTRL;
      else if (idx_hit(addr, `LDC_IDX_RES_ONE))
         decode = LDC_SEL_RES_ONE;
      else if (idx_hit(addr, `LDC_IDX_RES_TWO))
         decode = LDC_SEL_RES_TWO;
      else if (idx_hit(addr, `LDC_IDX_CKSUM_REAL))
         decode = LDC_SEL_CKSUM;
      else if (idx_hit(addr, `LDC_IDX_DESKEW))
         decode = LDC_SEL_DESKEW;
      else if (idx_hit(addr, `LDC_IDX_SOFT_RST))
         decode = LDC_SEL_SOFT_RST;
      else if (idx_hit(addr, `LDC_IDX_IRQ_STAT))
         decode = LDC_SEL_IRQ_STAT;
      else if (idx_hit(addr, `LDC_IDX_IRQ_MASK))
         decode = LDC_SEL_IRQ_MASK;
      else
         decode = LDC_SEL_NONE;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ldc_sel_type sel;
   logic setup;
   logic wr_en;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic [LINK_W-1:0] page_r;
   logic page_ok;
   logic soft_rst_r;
   logic [4:0] cbps_r;
   ldc_link_cfg_type cfg_r [NUM_LINKS];
   logic [LANES-1:0] deskew_flag [NUM_LINKS];
   logic [NUM_LINKS-1:0] gained;
   logic [NUM_LINKS-1:0] lost;
   logic [IRQ_W-1:0] irq_stat_r;
   logic [IRQ_W-1:0] irq_mask_r;
   logic [IRQ_W-1:0] irq_evt;
   logic [IRQ_W-1:0] irq_clr;
   logic [7:0] rd_byte;
   logic [31:0] rd_word;
   logic rd_err;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic irq_r;

   // ----------------------------------------------------------------
   // APB handshake
   // ----------------------------------------------------------------
   // Read data is captured in the setup cycle, so every access phase
   // completes at once with registered data and no wait states.
   assign sel = decode(paddr);
   assign setup = psel && !penable;
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign wr_lane0 = wr_en && pstrb[0];
   assign wbyte = pwdata[7:0];
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // A page beyond the implemented links reads zero and takes no writes.
   assign page_ok = (32'(page_r) < NUM_LINKS); // [R4]

   // ----------------------------------------------------------------
   // Link page and soft reset controls
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         page_r <= '0;
      else if (wr_lane0 && sel == LDC_SEL_PAGE)
         page_r <= wbyte[LINK_W-1:0]; // [R4]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         soft_rst_r <= `LDC_SOFT_RST_RESET;
      else if (wr_lane0 && sel == LDC_SEL_SOFT_RST)
         soft_rst_r <= wbyte[`LDC_SOFT_RST_BIT];
   end

   assign deskew_soft_rst = soft_rst_r;

   // ----------------------------------------------------------------
   // Control bits per sample
   // ----------------------------------------------------------------
   // Only link 0 carries this setting; it is sampled from the link
   // layer so that software sees the value the receiver really uses.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cbps_r <= `LDC_CBPS_RESET; // [R2]
      else
         cbps_r <= ctrl_bits_per_sample_field; // [R3]
   end

   // ----------------------------------------------------------------
   // Per-link parameter bytes and deskew status
   // ----------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < NUM_LINKS; k = k + 1)
      begin : gen_link
         logic this_page;

         assign this_page = (32'(page_r) == k);

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               cfg_r[k].res_one <= `LDC_BYTE_RESET; // [R5]
               cfg_r[k].res_two <= `LDC_BYTE_RESET; // [R5]
               cfg_r[k].cksum <= `LDC_BYTE_RESET;
            end
            else if (wr_lane0 && this_page)
            begin
               if (sel == LDC_SEL_RES_ONE)
                  cfg_r[k].res_one <= wbyte; // [R5]
               if (sel == LDC_SEL_RES_TWO)
                  cfg_r[k].res_two <= wbyte; // [R5]
               if (sel == LDC_SEL_CKSUM)
                  cfg_r[k].cksum <= wbyte;
            end
         end

         assign link_cfg[k] = cfg_r[k];

         ldc_lane_align #(
            .LANES(LANES)
         ) u_align (
            .pclk(pclk),
            .presetn(presetn),
            .soft_rst(soft_rst_r),
            .lane_evt(lane_evt[k]),
            .flag_r(deskew_flag[k]),
            .gained(gained[k]),
            .lost(lost[k])
         );

         assign irq_evt[2*k] = gained[k];
         assign irq_evt[2*k+1] = lost[k];
      end
   endgenerate

   // A checksum write outside soft reset is legal on the bus but breaks
   // the link contract, so it is flagged rather than refused.
   assign irq_evt[CKSUM_EVT] = wr_lane0 && sel == LDC_SEL_CKSUM && page_ok && !soft_rst_r; // [R6]

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   assign irq_clr = (wr_lane0 && sel == LDC_SEL_IRQ_STAT) ? wbyte[IRQ_W-1:0] : '0;

   // A new event wins over a clear written in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_r <= '0;
      else
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_mask_r <= '0;
      else if (wr_lane0 && sel == LDC_SEL_IRQ_MASK)
         irq_mask_r <= wbyte[IRQ_W-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(irq_stat_r & irq_mask_r);
   end

   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_byte = 8'h00;
      rd_err = 1'b0;
      case (sel)
         LDC_SEL_PAGE:
            rd_byte = 8'(page_r);
         LDC_SEL_DENS_CTRL:
         begin
            rd_byte[`LDC_DENS_BIT] = `LDC_DENS_VALUE; // [R1]
            if (page_r == '0)
               rd_byte[`LDC_CBPS_MSB:`LDC_CBPS_LSB] = cbps_r; // [R2] [R3]
         end
         LDC_SEL_RES_ONE:
            if (page_ok)
               rd_byte = cfg_r[page_r].res_one; // [R4] [R5]
         LDC_SEL_RES_TWO:
            if (page_ok)
               rd_byte = cfg_r[page_r].res_two; // [R4] [R5]
         LDC_SEL_CKSUM:
            if (page_ok)
               rd_byte = cfg_r[page_r].cksum; // [R4]
         LDC_SEL_DESKEW:
            if (page_ok)
               rd_byte = 8'(deskew_flag[page_r]); // [R4] [R7] [R8]
         LDC_SEL_SOFT_RST:
            rd_byte[`LDC_SOFT_RST_BIT] = soft_rst_r;
         LDC_SEL_IRQ_STAT:
            rd_byte = 8'(irq_stat_r);
         LDC_SEL_IRQ_MASK:
            rd_byte = 8'(irq_mask_r);
         LDC_SEL_NONE:
            rd_err = 1'b1;
         default:
            rd_err = 1'b1;
      endcase
      rd_word = {24'h000000, rd_byte};
   end

   // ----------------------------------------------------------------
   // Registered answer
   // ----------------------------------------------------------------
   // Captured in the setup cycle and held through the access phase.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h00000000;
      else if (setup)
         prdata_r <= pwrite ? 32'h00000000 : rd_word;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr_r <= 1'b0;
      else if (setup)
         pslverr_r <= rd_err;
   end

endmodule

`default_nettype wire

// >>> include/ldc_params.svh
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH

// Register indices; the byte address of each register is four times its index.
`define LDC_IDX_LINK_PAGE 12'h300
`define LDC_IDX_DENS_CTRL 12'h45A
`define LDC_IDX_RES_ONE 12'h45B
`define LDC_IDX_RES_TWO 12'h45C
`define LDC_IDX_CKSUM_REAL 12'h45D
`define LDC_IDX_DESKEW 12'h46C
`define LDC_IDX_SOFT_RST 12'h475
`define LDC_IDX_IRQ_STAT 12'h480
`define LDC_IDX_IRQ_MASK 12'h481

// Field positions.
`define LDC_DENS_BIT 7
`define LDC_CBPS_MSB 4
`define LDC_CBPS_LSB 0
`define LDC_SOFT_RST_BIT 3

// Reset and fixed values.
`define LDC_DENS_VALUE 1'h1
`define LDC_CBPS_RESET 5'h00
`define LDC_BYTE_RESET 8'h00
`define LDC_DESKEW_RESET 8'h00
`define LDC_SOFT_RST_RESET 1'h0

// Link geometry.
`define LDC_LANES 8
`define LDC_LINKS 2

`endif

// >>> include/ldc_pkg.sv
package ldc_pkg;

   // Per-lane alignment events from the lane alignment logic.
   typedef struct packed {
      logic [7:0] done;
      logic [7:0] lost;
   } ldc_lane_evt_type;

   // Writable per-link parameter bytes.
   typedef struct packed {
      logic [7:0] res_one;
      logic [7:0] res_two;
      logic [7:0] cksum;
   } ldc_link_cfg_type;

   // Decoded register selection.
   typedef enum {
      LDC_SEL_NONE,
      LDC_SEL_PAGE,
      LDC_SEL_DENS_CTRL,
      LDC_SEL_RES_ONE,
      LDC_SEL_RES_TWO,
      LDC_SEL_CKSUM,
      LDC_SEL_DESKEW,
      LDC_SEL_SOFT_RST,
      LDC_SEL_IRQ_STAT,
      LDC_SEL_IRQ_MASK
   } ldc_sel_type;

endpackage

// >>> test/ldc_lane_src.sv
`timescale 1ns/100ps
`default_nettype none
module ldc_lane_src (
   // Clock
   input wire logic pclk,
   // Alignment events towards the receiver
   output ldc_pkg::ldc_lane_evt_type evt
);
   import ldc_pkg::*;
   initial evt = '0;
   // The gap models a link that takes its time to align; keep it at least one.
   task automatic send(input int gap, input logic [7:0] d, input logic [7:0] l);
      repeat (gap) @(posedge pclk);
      evt <= '{done: d, lost: l};
      @(posedge pclk);
      evt <= '0;
   endtask
endmodule
`default_nettype wire

// >>> test/ldc_props.sv
`timescale 1ns/100ps
`default_nettype none
module ldc_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Link side
   input wire logic [4:0] ctrl_bits_per_sample_field,
   input wire logic deskew_soft_rst,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic page_r;
   sequence acc_s;
      psel && penable;
   endsequence
   sequence rd_hc_s;
      acc_s ##0 !pwrite && paddr == 16'h1168;
   endsequence
   // The checker follows the page selector itself, so paged reads can be judged.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         page_r <= 1'b0;
      else if (psel && penable && pwrite && pstrb[0] && paddr == 16'h0C00)
         page_r <= pwdata[0];
   end
   dens_bit_a: assert property (rd_hc_s |-> prdata[31:5] == 27'h4)
      else $error("density bit or upper bits wrong");
   cbps_page0_a: assert property (rd_hc_s ##0 !page_r |-> prdata[4:0] == $past(ctrl_bits_per_sample_field, 2))
      else $error("control bit count wrong on link 0");
   cbps_page1_a: assert property (rd_hc_s ##0 page_r |-> prdata[7:0] == 8'h80)
      else $error("control bit count shown on link 1");
   rd_stable_a: assert property (acc_s |=> $stable(prdata) && $stable(pslverr))
      else $error("read data moved after access");
   unmapped_err_a: assert property (acc_s ##0 paddr == 16'h0000 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");
   upper_zero_a: assert property (acc_s ##0 !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   soft_rst_a: assert property (acc_s ##0 pwrite && pstrb[0] && paddr == 16'h11D4
      |=> deskew_soft_rst == $past(pwdata[3]))
      else $error("soft reset bit not taken");
   rst_quiet_a: assert property ($rose(presetn) |-> !irq && !deskew_soft_rst && prdata == 32'h0)
      else $error("outputs not clear after reset");
endmodule
bind ldc_top ldc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .ctrl_bits_per_sample_field, .deskew_soft_rst, .irq);
`default_nettype wire

// >>> test/test_link_config_deskew_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"
module test_link_config_deskew_status;
   import ldc_pkg::*;
   localparam logic [15:0] A_PG = 16'(`LDC_IDX_LINK_PAGE) << 2;
   localparam logic [15:0] A_HC = 16'(`LDC_IDX_DENS_CTRL) << 2;
   localparam logic [15:0] A_R1 = 16'(`LDC_IDX_RES_ONE) << 2;
   localparam logic [15:0] A_R2 = 16'(`LDC_IDX_RES_TWO) << 2;
   localparam logic [15:0] A_CK = 16'(`LDC_IDX_CKSUM_REAL) << 2;
   localparam logic [15:0] A_DS = 16'(`LDC_IDX_DESKEW) << 2;
   localparam logic [15:0] A_SR = 16'(`LDC_IDX_SOFT_RST) << 2;
   localparam logic [15:0] A_IS = 16'(`LDC_IDX_IRQ_STAT) << 2;
   localparam logic [15:0] A_IM = 16'(`LDC_IDX_IRQ_MASK) << 2;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, deskew_soft_rst, irq, er;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [4:0] cbps;
   wire ldc_lane_evt_type evt [2];
   wire ldc_link_cfg_type cfg [2];
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   ldc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .ctrl_bits_per_sample_field(cbps), .lane_evt(evt), .link_cfg(cfg), .deskew_soft_rst, .irq);
   ldc_lane_src src0 (.pclk, .evt(evt[0]));
   ldc_lane_src src1 (.pclk, .evt(evt[1]));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ---------------------------------------------
   // Bus and comparison helpers
   // ---------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One idle cycle after each transfer keeps a signal from being driven twice in a step.
   task automatic xf(input logic w, input logic [15:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
      xf(1'b0, a, 8'h00);
      chk(nm, rd, exp);
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      rchk("page", A_PG, 32'h0);
      rchk("dens_ctrl", A_HC, 32'h80);
      rchk("resv_one", A_R1, 32'h0);
      rchk("resv_two", A_R2, 32'h0);
      rchk("cksum", A_CK, 32'h0);
      rchk("deskew", A_DS, 32'h0);
   endtask
   task automatic t_dens_ctrl();
      cbps <= 5'h15;
      xf(1'b1, A_HC, 8'h00);
      rchk("dens_ctrl", A_HC, 32'h95);
      xf(1'b1, A_PG, 8'h01);
      rchk("dens_ctrl_p1", A_HC, 32'h80);
      xf(1'b1, A_PG, 8'h00);
   endtask
   task automatic t_res();
      xf(1'b1, A_R1, 8'hA5);
      xf(1'b1, A_R2, 8'h5A);
      xf(1'b1, A_PG, 8'h01);
      xf(1'b1, A_R1, 8'h3C);
      xf(1'b1, A_R2, 8'hC3);
      pstrb <= 4'h0;
      xf(1'b1, A_R2, 8'hFF);
      pstrb <= 4'hF;
      rchk("resv_one_p1", A_R1, 32'h3C);
      rchk("resv_two_p1", A_R2, 32'hC3);
      xf(1'b1, A_PG, 8'h00);
      rchk("resv_one_p0", A_R1, 32'hA5);
      chk("cfg", {cfg[0].res_one, cfg[0].res_two, cfg[1].res_one, cfg[1].res_two}, 32'hA55A3CC3);
   endtask
   task automatic t_cksum();
      xf(1'b1, A_SR, 8'h08);
      chk("soft_rst", deskew_soft_rst, 32'h1);
      xf(1'b1, A_CK, 8'h77);
      xf(1'b1, A_SR, 8'h00);
      rchk("cksum", A_CK, 32'h77);
      chk("cfg_ck", cfg[0].cksum, 32'h77);
      rchk("irq_st0", A_IS, 32'h0);
      // Deliberately breaks the software ordering so that the misuse flag is exercised.
      xf(1'b1, A_CK, 8'h11);
      rchk("irq_ck_flag", A_IS, 32'h10);
      xf(1'b1, A_IS, 8'h10);
      rchk("irq_ck_clr", A_IS, 32'h0);
   endtask
   task automatic t_deskew();
      xf(1'b1, A_IM, 8'h01);
      src0.send(2, 8'hFF, 8'h00);
      repeat (2) @(posedge pclk);
      chk("irq_on", irq, 32'h1);
      rchk("deskew", A_DS, 32'hFF);
      xf(1'b1, A_DS, 8'h00);
      rchk("deskew_ro", A_DS, 32'hFF);
      xf(1'b1, A_IS, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq_off", irq, 32'h0);
      src0.send(1, 8'h00, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq_masked", irq, 32'h0);
      rchk("deskew_lost", A_DS, 32'hFE);
      rchk("irq_st", A_IS, 32'h02);
      xf(1'b1, A_PG, 8'h01);
      src1.send(1, 8'h0F, 8'h00);
      repeat (2) @(posedge pclk);
      rchk("deskew_p1", A_DS, 32'h0F);
      xf(1'b1, A_SR, 8'h08);
      rchk("deskew_srst", A_DS, 32'h0);
      xf(1'b1, A_SR, 8'h00);
      xf(1'b1, A_PG, 8'h00);
      xf(1'b0, 16'h0000, 8'h00);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      pstrb = 4'hF;
      cbps = 5'h00;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_dens_ctrl();
      t_res();
      t_cksum();
      t_deskew();
      print_verdict();
   end
endmodule
`default_nettype wire
